// ==== hdl/hulpl_defines.vh ====
// Purpose: Shared constants of the host serial link with the low-power handshake.
// Assumes: Included by its bare name from the link module.
// Notes:   Rates are nominal; the real rate is the core clock divided by an integer.
`ifndef HULPL_DEFINES_VH
`define HULPL_DEFINES_VH

// ****************************************************************
// Clocks
// ****************************************************************
`define HULPL_CLK_HZ 32'h0098_9680
`define HULPL_LP_CLK_HZ 32'h0000_8000

// ****************************************************************
// Nominal baud rates, by select code
// ****************************************************************
`define HULPL_BAUD_0 32'h0000_2580
`define HULPL_BAUD_1 32'h0000_4B00
`define HULPL_BAUD_2 32'h0000_9600
`define HULPL_BAUD_3 32'h0000_E100
`define HULPL_BAUD_4 32'h0001_C200
`define HULPL_BAUD_5 32'h0003_8400
`define HULPL_BAUD_6 32'h0007_0800
`define HULPL_BAUD_7 32'h000E_1000
`define HULPL_BAUD_8 32'h001C_2000
`define HULPL_BAUD_9 32'h0031_9750
`define HULPL_SEL_RESET 4'h4

// ****************************************************************
// Character framing and receive buffer depth
// ****************************************************************
`define HULPL_DATA_BITS 3'h7
`define HULPL_BUF_DEPTH 2

`endif

// ==== hdl/hulpl_link.v ====
// Purpose: Device end of the four-wire host serial link with low-power handshake.
// Assumes: One core clock; all pin inputs are asynchronous to it.
// Notes:   Received words pass a small buffer; receive flow control follows its fill.
`timescale 1ns/1ps
`include "hulpl_defines.vh"

module hulpl_link #(
    parameter CLK_HZ = `HULPL_CLK_HZ,
    parameter DEPTH = `HULPL_BUF_DEPTH,
    parameter AW = 1
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // Transmit words from the device core
    input wire [7:0] i_tx_data,
    input wire i_tx_valid,
    output reg o_tx_ready_q,
    // Received words toward the device core
    output reg [7:0] o_rx_data_q,
    output reg o_rx_valid_q,
    input wire i_rx_ready,
    output reg o_rx_error_q,
    // Rate selection
    input wire [3:0] i_baud_sel,
    input wire i_baud_load,
    // Serial pins
    output reg o_serial_tx_line_q,
    input wire i_serial_rx_line,
    output reg o_request_to_send_out_n_q,
    input wire i_clear_to_send_in_n,
    // Low-power handshake
    input wire i_host_sleep_permit_in,
    input wire i_wake_req,
    output reg o_host_wake_out_q,
    output reg o_lowpower_q,
    output reg o_lp_tick_q
);
    localparam ST_IDLE = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_DATA = 2'd2;
    localparam ST_STOP = 2'd3;
    localparam [31:0] LP_DIV = CLK_HZ / `HULPL_LP_CLK_HZ;

    // Integer divisor for a select code; unknown codes keep the default rate.
    function [15:0] baud_div;
        input [3:0] sel;
        reg [31:0] rate;
        reg [31:0] quot;
        begin
            case (sel)
                4'h0: rate = `HULPL_BAUD_0;
                4'h1: rate = `HULPL_BAUD_1;
                4'h2: rate = `HULPL_BAUD_2;
                4'h3: rate = `HULPL_BAUD_3;
                4'h5: rate = `HULPL_BAUD_5;
                4'h6: rate = `HULPL_BAUD_6;
                4'h7: rate = `HULPL_BAUD_7;
                4'h8: rate = `HULPL_BAUD_8;
                4'h9: rate = `HULPL_BAUD_9;
                default: rate = `HULPL_BAUD_4;
            endcase
            // Every supported rate gives a divisor that fits in the 16-bit counters.
            quot = CLK_HZ / rate;
            baud_div = quot[15:0];
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg rx_m_q, rx_s_q, cts_m_q, cts_s_q, slp_m_q, slp_s_q;
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            cts_m_q <= 1'b1;
            cts_s_q <= 1'b1;
            slp_m_q <= 1'b0;
            slp_s_q <= 1'b0;
        end else begin
            rx_m_q <= i_serial_rx_line;
            rx_s_q <= rx_m_q;
            cts_m_q <= i_clear_to_send_in_n;
            cts_s_q <= cts_m_q;
            slp_m_q <= i_host_sleep_permit_in;
            slp_s_q <= slp_m_q;
        end
    end

    // ****************************************************************
    // Rate divisor
    // ****************************************************************
    reg [15:0] div_q;
    reg [1:0] tx_st_q, rx_st_q;
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            div_q <= baud_div(`HULPL_SEL_RESET);
        end else if (i_baud_load && tx_st_q == ST_IDLE && rx_st_q == ST_IDLE) begin
            div_q <= baud_div(i_baud_sel);
        end
    end

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    reg [15:0] tx_cnt_q;
    reg [2:0] tx_bit_q;
    reg [7:0] tx_sh_q;
    wire tx_take = i_tx_valid && o_tx_ready_q;
    wire tx_tick = (tx_cnt_q == div_q - 16'd1);
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            tx_st_q <= ST_IDLE;
            tx_cnt_q <= 16'd0;
            tx_bit_q <= 3'd0;
            tx_sh_q <= 8'd0;
            o_serial_tx_line_q <= 1'b1;
            o_tx_ready_q <= 1'b0;
        end else begin
            tx_cnt_q <= (tx_st_q == ST_IDLE || tx_tick) ? 16'd0 : tx_cnt_q + 16'd1;
            case (tx_st_q)
                ST_IDLE: begin
                    o_tx_ready_q <= !cts_s_q && !tx_take;
                    if (tx_take) begin
                        tx_sh_q <= i_tx_data;
                        o_serial_tx_line_q <= 1'b0;
                        tx_st_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_tick) begin
                        o_serial_tx_line_q <= tx_sh_q[0];
                        tx_bit_q <= 3'd0;
                        tx_st_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit_q == `HULPL_DATA_BITS) begin
                            o_serial_tx_line_q <= 1'b1;
                            tx_st_q <= ST_STOP;
                        end else begin
                            o_serial_tx_line_q <= tx_sh_q[tx_bit_q + 3'd1];
                            tx_bit_q <= tx_bit_q + 3'd1;
                        end
                    end
                end
                default: begin
                    if (tx_tick) begin
                        tx_st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Receiver
    // ****************************************************************
    reg [15:0] rx_cnt_q;
    reg [2:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg push;
    reg [AW:0] cnt_q, cnt_d;
    wire full = (cnt_q == DEPTH);
    wire rx_tick = (rx_cnt_q == div_q - 16'd1);
    wire rx_half = (rx_cnt_q == {1'b0, div_q[15:1]});
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_st_q <= ST_IDLE;
            rx_cnt_q <= 16'd0;
            rx_bit_q <= 3'd0;
            rx_sh_q <= 8'd0;
            push <= 1'b0;
            o_rx_error_q <= 1'b0;
        end else begin
            push <= 1'b0;
            o_rx_error_q <= 1'b0;
            rx_cnt_q <= (rx_st_q == ST_IDLE || rx_tick) ? 16'd0 : rx_cnt_q + 16'd1;
            case (rx_st_q)
                ST_IDLE: begin
                    if (!rx_s_q) begin
                        rx_st_q <= ST_START;
                    end
                end
                ST_START: begin
                    // Centre on the start bit; a short glitch returns to idle.
                    if (rx_half) begin
                        rx_cnt_q <= 16'd0;
                        rx_bit_q <= 3'd0;
                        rx_st_q <= rx_s_q ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_tick) begin
                        rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'd1;
                        if (rx_bit_q == `HULPL_DATA_BITS) begin
                            rx_st_q <= ST_STOP;
                        end
                    end
                end
                default: begin
                    if (rx_tick) begin
                        rx_st_q <= ST_IDLE;
                        // The drop is decided once, at the stop bit, so the error pulse
                        // and the lost word always agree.
                        push <= rx_s_q && !full;
                        o_rx_error_q <= !rx_s_q || full;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Receive buffer
    // ****************************************************************
    reg [7:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_q, rptr_q, rptr_d;
    reg [7:0] head_d;
    reg wr, rd;
    always @* begin
        wr = push && !full;
        rd = o_rx_valid_q && i_rx_ready;
        rptr_d = rd ? rptr_q + 1'b1 : rptr_q;
        cnt_d = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
        head_d = (wr && wptr_q == rptr_d) ? rx_sh_q : mem[rptr_d];
    end
    always @(posedge i_core_clk) begin
        if (wr) begin
            mem[wptr_q] <= rx_sh_q;
        end
        if (i_rst) begin
            wptr_q <= {AW{1'b0}};
            rptr_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            o_rx_valid_q <= 1'b0;
            o_rx_data_q <= 8'd0;
            o_request_to_send_out_n_q <= 1'b1;
        end else begin
            if (wr) begin
                wptr_q <= wptr_q + 1'b1;
            end
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            o_rx_valid_q <= (cnt_d != 0);
            o_rx_data_q <= head_d;
            // Hold the host off while a word waits, leaving one slot for a word in flight.
            o_request_to_send_out_n_q <= (cnt_d != 0);
        end
    end

    // ****************************************************************
    // Low-power handshake
    // ****************************************************************
    reg [31:0] lp_cnt_q;
    wire busy = (tx_st_q != ST_IDLE) || (rx_st_q != ST_IDLE) || (cnt_q != 0);
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            lp_cnt_q <= 32'd0;
            o_lp_tick_q <= 1'b0;
            o_lowpower_q <= 1'b0;
            o_host_wake_out_q <= 1'b0;
        end else begin
            o_lowpower_q <= slp_s_q && !busy && !i_wake_req && !i_tx_valid;
            o_host_wake_out_q <= i_wake_req || i_tx_valid;
            // The slow tick runs only in low power mode, standing in for the 32 kHz clock.
            o_lp_tick_q <= o_lowpower_q && (lp_cnt_q == LP_DIV - 32'd1);
            if (!o_lowpower_q || lp_cnt_q == LP_DIV - 32'd1) begin
                lp_cnt_q <= 32'd0;
            end else begin
                lp_cnt_q <= lp_cnt_q + 32'd1;
            end
        end
    end

endmodule

// ==== sim/hulpl_link_asserts.sv ====
// Purpose: Timing checks on the pins of the host serial link.
// Assumes: Rate codes are loaded only while the link is idle.
// Notes:   The cycle counter mirrors the frame so each bit is tied to its moment.
`timescale 1ns/1ps
`include "hulpl_defines.vh"
module hulpl_link_asserts #(
    parameter CLK_HZ = `HULPL_CLK_HZ
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire [7:0] i_tx_data,
    input wire i_tx_valid,
    input wire o_tx_ready_q,
    input wire [3:0] i_baud_sel,
    input wire i_baud_load,
    input wire o_serial_tx_line_q,
    input wire o_rx_valid_q,
    input wire o_request_to_send_out_n_q,
    input wire i_clear_to_send_in_n,
    input wire i_host_sleep_permit_in,
    input wire i_wake_req,
    input wire o_host_wake_out_q,
    input wire o_lowpower_q,
    input wire o_lp_tick_q
);
    localparam [319:0] RATES = {`HULPL_BAUD_9, `HULPL_BAUD_8, `HULPL_BAUD_7, `HULPL_BAUD_6,
        `HULPL_BAUD_5, `HULPL_BAUD_4, `HULPL_BAUD_3, `HULPL_BAUD_2, `HULPL_BAUD_1, `HULPL_BAUD_0};
    wire [31:0] sel_rate = (i_baud_sel > 4'h9) ? `HULPL_BAUD_4 : RATES[i_baud_sel * 32 +: 32];
    wire take = i_tx_valid && o_tx_ready_q;
    reg [31:0] div_q;
    reg [31:0] cnt_q;
    reg [7:0] dat_q;
    // Counter value k means the k-th cycle of the frame is on the line.
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            div_q <= CLK_HZ / `HULPL_BAUD_4;
            cnt_q <= 32'h0000_0000;
        end else begin
            if (i_baud_load && cnt_q == 0)
                div_q <= CLK_HZ / sel_rate;
            if (take) begin
                cnt_q <= 32'h0000_0001;
                dat_q <= i_tx_data;
            end else if (cnt_q != 0 && cnt_q < 10 * div_q)
                cnt_q <= cnt_q + 1;
            else
                cnt_q <= 32'h0000_0000;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    AST_START_BIT: assert property ((cnt_q >= 1 && cnt_q <= div_q) |-> !o_serial_tx_line_q)
        else $error("start bit not low for one bit time");
    AST_DATA_BITS: assert property ((cnt_q > div_q && cnt_q <= 9 * div_q) |->
        o_serial_tx_line_q == dat_q[(cnt_q - 1) / div_q - 1]) else $error("data bit wrong");
    AST_IDLE_STOP: assert property ((cnt_q == 0 || cnt_q > 9 * div_q) |-> o_serial_tx_line_q)
        else $error("line low outside start and data bits");
    AST_BUSY_NOT_READY: assert property (cnt_q != 0 |-> !o_tx_ready_q)
        else $error("ready during a frame");
    AST_CTS_HOLD: assert property (i_clear_to_send_in_n [*5] |-> !o_tx_ready_q)
        else $error("ready while host refuses");
    AST_RTS_FULL: assert property (o_rx_valid_q |-> o_request_to_send_out_n_q)
        else $error("request to send while buffer holds a word");
    AST_WAKE: assert property (!$past(i_rst) |->
        o_host_wake_out_q == $past(i_wake_req || i_tx_valid)) else $error("wake output wrong");
    AST_LP_PERMIT: assert property (o_lowpower_q |-> $past(i_host_sleep_permit_in, 3))
        else $error("low power without permission");
    AST_TICK: assert property (o_lp_tick_q |=> !o_lp_tick_q [*8])
        else $error("low power tick too close");
endmodule
bind hulpl_link hulpl_link_asserts #(.CLK_HZ(CLK_HZ)) u_chk (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready_q(o_tx_ready_q),
    .i_baud_sel(i_baud_sel), .i_baud_load(i_baud_load), .o_rx_valid_q(o_rx_valid_q),
    .o_serial_tx_line_q(o_serial_tx_line_q), .i_clear_to_send_in_n(i_clear_to_send_in_n),
    .o_request_to_send_out_n_q(o_request_to_send_out_n_q), .i_wake_req(i_wake_req),
    .i_host_sleep_permit_in(i_host_sleep_permit_in), .o_host_wake_out_q(o_host_wake_out_q),
    .o_lowpower_q(o_lowpower_q), .o_lp_tick_q(o_lp_tick_q));

// ==== sim/hulpl_host_model.sv ====
// Purpose: Host end of the serial link.
// Assumes: Bit time in core cycles is set by the bench.
// Notes:   Samples at bit centre only, so a skewed rate shows as wrong bits.
`timescale 1ns/1ps
module hulpl_host_model (
    input wire i_clk,
    input wire i_from_dev,
    input wire i_rts_n,
    output logic o_to_dev
);
    int div = 86;
    bit obey = 1;
    logic [7:0] got[$];
    initial o_to_dev = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (obey && i_rts_n !== 1'b0) @(negedge i_clk);
        for (int i = 0; i < 10; i++) begin
            o_to_dev = f[i];
            repeat (div) @(negedge i_clk);
        end
    endtask
    always begin
        logic [7:0] b;
        @(negedge i_from_dev);
        repeat (div / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(negedge i_clk);
            b[i] = i_from_dev;
        end
        repeat (div) @(negedge i_clk);
        got.push_back(b);
    end
endmodule

// ==== sim/test_hulpl_link.sv ====
// Purpose: Self-checking bench of the host serial link.
// Assumes: Default core clock parameter at a 100 ns period.
// Notes:   Rates are judged by the length of the start bit.
`timescale 1ns/1ps
`include "hulpl_defines.vh"
module test_hulpl_link;
    logic clk = 0, rst = 1, tx_valid = 0, rx_ready = 0, load = 0;
    logic cts_n = 0, permit = 0, wake = 0;
    logic [7:0] tx_data = 8'h00;
    logic [3:0] sel = 4'h4;
    wire rx_line, tx_line, tx_ready, rx_valid, rx_err, rts_n, wake_o, lp, tick;
    wire [7:0] rx_data;
    int fails = 0, checked = 0, errs = 0;
    hulpl_link i_dut (.i_core_clk(clk), .i_rst(rst), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
        .o_tx_ready_q(tx_ready), .o_rx_data_q(rx_data), .o_rx_valid_q(rx_valid),
        .i_rx_ready(rx_ready), .o_rx_error_q(rx_err), .i_baud_sel(sel), .i_baud_load(load),
        .o_serial_tx_line_q(tx_line), .i_serial_rx_line(rx_line), .i_wake_req(wake),
        .o_request_to_send_out_n_q(rts_n), .i_clear_to_send_in_n(cts_n),
        .i_host_sleep_permit_in(permit), .o_host_wake_out_q(wake_o), .o_lowpower_q(lp),
        .o_lp_tick_q(tick));
    hulpl_host_model i_host (.i_clk(clk), .i_from_dev(tx_line), .i_rts_n(rts_n),
        .o_to_dev(rx_line));
    initial forever #50 clk = ~clk;
    always @(negedge clk) if (rx_err === 1'b1) errs++;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task send_tx(input logic [7:0] d);
        int n;
        @(negedge clk);
        tx_data = d;
        tx_valid = 1;
        n = 0;
        while (tx_ready !== 1'b1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        tx_valid = 0;
    endtask
    task wait_rx;
        int n;
        n = 0;
        while (i_host.got.size() < 1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        chk(i_host.got.size(), 1);
    endtask
    task t_tx;
        send_tx(8'hA5);
        send_tx(8'h3C);
        repeat (900) @(negedge clk);
        chk(i_host.got.pop_front(), 8'hA5);
        chk(i_host.got.pop_front(), 8'h3C);
    endtask
    // The host ignores flow control here so the third word meets a full buffer.
    task t_rx;
        i_host.obey = 0;
        i_host.send(8'h11);
        i_host.send(8'h22);
        i_host.send(8'h33);
        repeat (90) @(negedge clk);
        chk(rts_n, 1'b1);
        chk(errs, 1);
        rx_ready = 1;
        chk(rx_data, 8'h11);
        @(negedge clk);
        chk(rx_data, 8'h22);
        @(negedge clk);
        rx_ready = 0;
        chk(rx_valid, 1'b0);
        repeat (3) @(negedge clk);
        chk(rts_n, 1'b0);
        i_host.obey = 1;
    endtask
    task t_cts;
        send_tx(8'hC3);
        repeat (100) @(negedge clk);
        cts_n = 1;
        wait_rx;
        chk(i_host.got.pop_front(), 8'hC3);
        fork
            send_tx(8'h5A);
            begin
                repeat (900) @(negedge clk);
                chk(tx_line, 1'b1);
                chk(tx_ready, 1'b0);
                cts_n = 0;
            end
        join
        wait_rx;
        chk(i_host.got.pop_front(), 8'h5A);
    endtask
    task t_baud;
        int unsigned rate[11];
        int n;
        rate = '{9600, 19200, 38400, 57600, 115200, 230400, 460800,
            921600, 1843200, 3250000, 115200};
        for (int i = 0; i < 11; i++) begin
            n = 0;
            while (tx_ready !== 1'b1 && n < 30000) begin
                @(negedge clk);
                n++;
            end
            sel = (i < 10) ? i[3:0] : 4'hF;
            load = 1;
            @(negedge clk);
            load = 0;
            i_host.div = `HULPL_CLK_HZ / rate[i];
            send_tx(8'h01);
            n = 0;
            while (tx_line === 1'b0 && n < 30000) begin
                @(negedge clk);
                n++;
            end
            chk(n, `HULPL_CLK_HZ / rate[i]);
            wait_rx;
            chk(i_host.got.pop_front(), 8'h01);
        end
    endtask
    task t_lp;
        int n;
        permit = 1;
        repeat (100) @(negedge clk);
        chk(lp, 1'b1);
        n = 0;
        while (tick !== 1'b1 && n < 999) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tick !== 1'b1 && n < 999);
        chk(n, `HULPL_CLK_HZ / `HULPL_LP_CLK_HZ);
        wake = 1;
        @(negedge clk);
        chk(wake_o, 1'b1);
        repeat (3) @(negedge clk);
        chk(lp, 1'b0);
        wake = 0;
        permit = 0;
    endtask
    // Reset lands in mid-frame; the host's half-received word is thrown away.
    task t_reset;
        send_tx(8'h00);
        repeat (200) @(negedge clk);
        rst = 1;
        repeat (3) @(negedge clk);
        chk(tx_line, 1'b1);
        chk(tx_ready, 1'b0);
        chk(rts_n, 1'b1);
        rst = 0;
        repeat (900) @(negedge clk);
        i_host.got.delete();
        send_tx(8'h96);
        wait_rx;
        chk(i_host.got.pop_front(), 8'h96);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        repeat (3) @(negedge clk);
        t_tx;
        t_rx;
        t_cts;
        t_baud;
        t_lp;
        t_reset;
        wrap_up;
    end
    initial begin
        #10_000_000;
        fails++;
        wrap_up;
    end
endmodule
